// ---- src/rocm_cfg.svh ----
`ifndef ROCM_CFG_SVH
`define ROCM_CFG_SVH

// ---------------------------------------------------------------
// channel numbers of the eight output words
// ---------------------------------------------------------------
`define ROCM_CH_CTRL_STATUS 3'h0
`define ROCM_CH_TRANSPORT 3'h1
`define ROCM_CH_OPTION 3'h2
`define ROCM_CH_INDICATOR 3'h3
`define ROCM_CH_MOTION 3'h4
`define ROCM_CH_FONT 3'h5
`define ROCM_CH_VIDEO 3'h6
`define ROCM_CH_IMAGE 3'h7
`define ROCM_CH_COUNT 8
`define ROCM_WORD_RESET 16'h0000

// ---------------------------------------------------------------
// bit positions; line xx00 carries weight 2^15
// ---------------------------------------------------------------
`define ROCM_BIT_ALIVE 15
`define ROCM_BIT_REV_ACCEL 13
`define ROCM_BIT_HALT 11
`define ROCM_BIT_CLEAR_CHAR 7
`define ROCM_SPEED_HI 3
`define ROCM_SPEED_LO 0
`define ROCM_BIT_MARK_SENSE 15
`define ROCM_BIT_NUMERIC 14
`define ROCM_BIT_ALPHA5 12
`define ROCM_BIT_ALPHA21 11
`define ROCM_ALT_FONT_HI 7
`define ROCM_ALT_FONT_LO 5
`define ROCM_PITCH_HI 4
`define ROCM_PITCH_LO 3
`define ROCM_BIT_THICKEN 15
`define ROCM_BIT_BLACK_FILL 14
`define ROCM_VACC_HI 13
`define ROCM_VACC_LO 8
`define ROCM_QUANT_HI 7
`define ROCM_QUANT_LO 0
`define ROCM_IMG_HI 15
`define ROCM_IMG_LO 2
`define ROCM_IMG_CTL_HI 1
`define ROCM_IMG_CTL_LO 0

// ---------------------------------------------------------------
// pitch codes and their characters per inch
// ---------------------------------------------------------------
`define ROCM_PITCH_CODE_10 2'h0
`define ROCM_PITCH_CODE_8 2'h1
`define ROCM_PITCH_CODE_7 2'h2
`define ROCM_CPI_10 4'hA
`define ROCM_CPI_8 4'h8
`define ROCM_CPI_7 4'h7
`define ROCM_CPI_OPEN 4'h0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ROCM_CLK_HZ 50000000
`define ROCM_ACCEL_IPS2 62000
`define ROCM_ACCEL_STEP_CYC (`ROCM_CLK_HZ / `ROCM_ACCEL_IPS2)
`define ROCM_NOMINAL_IPS 16'h004B
`define ROCM_SPEED_LIMIT 16'hFFFF
`define ROCM_ALIVE_MS 100
`define ROCM_ALIVE_CYC (`ROCM_CLK_HZ / 1000 * `ROCM_ALIVE_MS)

`endif

// ---- src/rocm_pkg.sv ----
package rocm_pkg;

  // mirror motion phases
  typedef enum logic [1:0] {
    ROCM_MIR_IDLE,
    ROCM_MIR_ACCEL,
    ROCM_MIR_DECEL,
    ROCM_MIR_CRUISE
  } rocm_mir_state_t;

  // one channel write from the controller
  typedef struct packed {
    logic write;
    logic [2:0] sel;
    logic [15:0] data;
  } rocm_chan_wr_t;

  // recognition matrix enables
  typedef struct packed {
    logic [2:0] altFont;
    logic numeric19;
    logic numericZero;
    logic alpha5;
    logic alpha21;
  } rocm_matrix_en_t;

  // video shaping settings
  typedef struct packed {
    logic thicken;
    logic blackFill;
    logic [5:0] vertAccum;
    logic [7:0] quant;
  } rocm_video_t;

endpackage : rocm_pkg

// ---- src/rocm_mirror_drive.sv ----
`timescale 1ns/1ns
`include "rocm_cfg.svh"

module rocm_mirror_drive (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic accelReverse,
  input wire logic haltCmd,
  output rocm_pkg::rocm_mir_state_t mirState,
  output logic [15:0] mirSpeed
);

  localparam logic [9:0] STEP_LAST = 10'(`ROCM_ACCEL_STEP_CYC - 1);

  rocm_pkg::rocm_mir_state_t state_ff;
  rocm_pkg::rocm_mir_state_t nxt_state;
  logic [15:0] speed_ff;
  logic [15:0] nxt_speed;
  logic [9:0] step_ff;
  logic [9:0] nxt_step;
  logic tick;

  // ---------------------------------------------------------------
  // motion profile
  // ---------------------------------------------------------------
  // one ips change per step gives the fixed acceleration; halt wins
  always_comb begin
    tick = (step_ff == STEP_LAST);
    nxt_state = state_ff;
    nxt_speed = speed_ff;
    nxt_step = tick ? 10'h000 : step_ff + 10'h001;
    case (state_ff)
      rocm_pkg::ROCM_MIR_IDLE: begin
        nxt_step = 10'h000;
        if (accelReverse && !haltCmd) begin
          nxt_state = rocm_pkg::ROCM_MIR_ACCEL;
        end
      end
      rocm_pkg::ROCM_MIR_ACCEL: begin
        if (haltCmd) begin
          nxt_state = rocm_pkg::ROCM_MIR_IDLE;
          nxt_speed = 16'h0000;
        end else if (!accelReverse) begin
          nxt_state = rocm_pkg::ROCM_MIR_DECEL;
        end else if (tick && speed_ff != `ROCM_SPEED_LIMIT) begin
          nxt_speed = speed_ff + 16'h0001;
        end
      end
      rocm_pkg::ROCM_MIR_DECEL: begin
        if (haltCmd) begin
          nxt_state = rocm_pkg::ROCM_MIR_IDLE;
          nxt_speed = 16'h0000;
        end else if (accelReverse) begin
          nxt_state = rocm_pkg::ROCM_MIR_ACCEL;
        end else if (speed_ff == `ROCM_NOMINAL_IPS) begin
          nxt_state = rocm_pkg::ROCM_MIR_CRUISE;
        end else if (tick) begin
          // a short burst below nominal is brought up to it
          nxt_speed = (speed_ff > `ROCM_NOMINAL_IPS) ? speed_ff - 16'h0001 :
                      speed_ff + 16'h0001;
        end
      end
      default: begin
        // cruise at nominal speed until told to stop or to accelerate again
        if (haltCmd) begin
          nxt_state = rocm_pkg::ROCM_MIR_IDLE;
          nxt_speed = 16'h0000;
        end else if (accelReverse) begin
          nxt_state = rocm_pkg::ROCM_MIR_ACCEL;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= rocm_pkg::ROCM_MIR_IDLE;
      speed_ff <= 16'h0000;
      step_ff <= 10'h000;
    end else begin
      state_ff <= nxt_state;
      speed_ff <= nxt_speed;
      step_ff <= nxt_step;
    end
  end

  assign mirState = state_ff;
  assign mirSpeed = speed_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence accelHeld;
    state_ff == rocm_pkg::ROCM_MIR_ACCEL && accelReverse && !haltCmd;
  endsequence

  accel_step_a: assert property (accelHeld ##0 (tick && speed_ff != `ROCM_SPEED_LIMIT)
    |=> speed_ff == $past(speed_ff) + 16'h0001)
    else $error("accel step missing");

  accel_steady_a: assert property (accelHeld ##0 !tick |=> $stable(speed_ff))
    else $error("speed moved between steps");

  cruise_speed_a: assert property (state_ff == rocm_pkg::ROCM_MIR_CRUISE
    |-> speed_ff == `ROCM_NOMINAL_IPS)
    else $error("cruise not at nominal speed");

  halt_stop_a: assert property (haltCmd && state_ff != rocm_pkg::ROCM_MIR_IDLE
    |=> state_ff == rocm_pkg::ROCM_MIR_IDLE && speed_ff == 16'h0000)
    else $error("halt did not stop mirror");

endmodule : rocm_mirror_drive

// ---- src/rocm_reader_map.sv ----
`timescale 1ns/1ns
`include "rocm_cfg.svh"

// Overview of operation
// - reverse accel line high drives mirror speed up from zero at fixed acceleration.
// - releasing accel line decelerates mirror at same rate to 75 ips.
// - each alternate font line enables one installed optional character set.
// - numeric line enables only digit matrices 1 through 9.
// - five-letter alpha line enables matrices C, S, T, X, Z.
// - twenty-one-letter alpha line enables the remaining letter matrices.
// - pitch code 00 is 10 cpi, 01 is 8, 10 is 7, 11 open.
module rocm_reader_map #(
  parameter int unsigned ALIVE_TIMEOUT_CYC = `ROCM_ALIVE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input rocm_pkg::rocm_chan_wr_t chanWr,
  output logic [15:0] controllerStatus,
  output logic [15:0] transportStatus,
  output logic [15:0] readerOption,
  output logic [15:0] indicatorControl,
  output rocm_pkg::rocm_mir_state_t mirState,
  output logic [15:0] mirSpeed,
  output rocm_pkg::rocm_matrix_en_t matrixEn,
  output logic [3:0] charsPerInch,
  output logic pitchOpen,
  output logic [3:0] advanceSpeed,
  output logic speedConflict,
  output rocm_pkg::rocm_video_t videoSet,
  output logic [13:0] imageColumn,
  output logic [1:0] imageCtl,
  output logic clearCharPulse,
  output logic powerShutdown
);

  localparam logic [22:0] ALIVE_LAST = 23'(ALIVE_TIMEOUT_CYC - 1);

  // ---------------------------------------------------------------
  // channel word store
  // ---------------------------------------------------------------
  logic [15:0] word_ff [`ROCM_CH_COUNT];
  logic [15:0] nxt_word [`ROCM_CH_COUNT];

  // only the addressed word changes; the rest keep their lines steady
  always_comb begin
    for (int i = 0; i < `ROCM_CH_COUNT; i++) begin
      nxt_word[i] = word_ff[i];
    end
    if (chanWr.write) begin
      nxt_word[chanWr.sel] = chanWr.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `ROCM_CH_COUNT; i++) begin
        word_ff[i] <= `ROCM_WORD_RESET;
      end
    end else begin
      for (int i = 0; i < `ROCM_CH_COUNT; i++) begin
        word_ff[i] <= nxt_word[i];
      end
    end
  end

  // status words go out as held, bit 15 first
  assign controllerStatus = word_ff[`ROCM_CH_CTRL_STATUS];
  assign transportStatus = word_ff[`ROCM_CH_TRANSPORT];
  assign readerOption = word_ff[`ROCM_CH_OPTION];
  assign indicatorControl = word_ff[`ROCM_CH_INDICATOR];

  // ---------------------------------------------------------------
  // mirror drive
  // ---------------------------------------------------------------
  logic [15:0] motionWord;
  assign motionWord = word_ff[`ROCM_CH_MOTION];

  // a plain level per line, so the controller owns pulse widths
  rocm_mirror_drive u_mirror (
    .mclk(mclk),
    .rst_n(rst_n),
    .accelReverse(motionWord[`ROCM_BIT_REV_ACCEL]),
    .haltCmd(motionWord[`ROCM_BIT_HALT]),
    .mirState(mirState),
    .mirSpeed(mirSpeed)
  );

  // ---------------------------------------------------------------
  // decoded reader settings
  // ---------------------------------------------------------------
  rocm_pkg::rocm_matrix_en_t matrix_ff;
  rocm_pkg::rocm_matrix_en_t nxt_matrix;
  rocm_pkg::rocm_video_t video_ff;
  rocm_pkg::rocm_video_t nxt_video;
  logic [3:0] cpi_ff;
  logic [3:0] nxt_cpi;
  logic open_ff;
  logic nxt_open;
  logic [3:0] speed_ff;
  logic [3:0] nxt_speedSel;
  logic conflict_ff;
  logic nxt_conflict;
  logic [13:0] img_ff;
  logic [13:0] nxt_img;
  logic [1:0] imgCtl_ff;
  logic [1:0] nxt_imgCtl;
  logic [15:0] fontWord;
  logic [15:0] videoWord;
  logic [15:0] imageWord;
  logic [1:0] pitchCode;

  assign fontWord = word_ff[`ROCM_CH_FONT];
  assign videoWord = word_ff[`ROCM_CH_VIDEO];
  assign imageWord = word_ff[`ROCM_CH_IMAGE];
  assign pitchCode = fontWord[`ROCM_PITCH_HI:`ROCM_PITCH_LO];

  // one cycle behind the word; settings are levels, latency is harmless
  always_comb begin
    nxt_matrix.altFont = fontWord[`ROCM_ALT_FONT_HI:`ROCM_ALT_FONT_LO];
    nxt_matrix.numeric19 = fontWord[`ROCM_BIT_NUMERIC];
    // zero needs mark sense on top of numeric
    nxt_matrix.numericZero = fontWord[`ROCM_BIT_NUMERIC] &
                             fontWord[`ROCM_BIT_MARK_SENSE];
    nxt_matrix.alpha5 = fontWord[`ROCM_BIT_ALPHA5];
    nxt_matrix.alpha21 = fontWord[`ROCM_BIT_ALPHA21];
    nxt_open = 1'b0;
    if (pitchCode == `ROCM_PITCH_CODE_10) begin
      nxt_cpi = `ROCM_CPI_10;
    end else if (pitchCode == `ROCM_PITCH_CODE_8) begin
      nxt_cpi = `ROCM_CPI_8;
    end else if (pitchCode == `ROCM_PITCH_CODE_7) begin
      nxt_cpi = `ROCM_CPI_7;
    end else begin
      nxt_cpi = `ROCM_CPI_OPEN;
      nxt_open = 1'b1;
    end
    nxt_speedSel = motionWord[`ROCM_SPEED_HI:`ROCM_SPEED_LO];
    // more than one speed line is flagged, never resolved here
    nxt_conflict = ($countones(nxt_speedSel) > 1);
    nxt_video.thicken = videoWord[`ROCM_BIT_THICKEN];
    nxt_video.blackFill = videoWord[`ROCM_BIT_BLACK_FILL];
    nxt_video.vertAccum = videoWord[`ROCM_VACC_HI:`ROCM_VACC_LO];
    nxt_video.quant = videoWord[`ROCM_QUANT_HI:`ROCM_QUANT_LO];
    nxt_img = imageWord[`ROCM_IMG_HI:`ROCM_IMG_LO];
    nxt_imgCtl = imageWord[`ROCM_IMG_CTL_HI:`ROCM_IMG_CTL_LO];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      matrix_ff <= '0;
      video_ff <= '0;
      cpi_ff <= `ROCM_CPI_10;
      open_ff <= 1'b0;
      speed_ff <= 4'h0;
      conflict_ff <= 1'b0;
      img_ff <= 14'h0000;
      imgCtl_ff <= 2'h0;
    end else begin
      matrix_ff <= nxt_matrix;
      video_ff <= nxt_video;
      cpi_ff <= nxt_cpi;
      open_ff <= nxt_open;
      speed_ff <= nxt_speedSel;
      conflict_ff <= nxt_conflict;
      img_ff <= nxt_img;
      imgCtl_ff <= nxt_imgCtl;
    end
  end

  assign matrixEn = matrix_ff;
  assign charsPerInch = cpi_ff;
  assign pitchOpen = open_ff;
  assign advanceSpeed = speed_ff;
  assign speedConflict = conflict_ff;
  assign videoSet = video_ff;
  assign imageColumn = img_ff;
  assign imageCtl = imgCtl_ff;

  // ---------------------------------------------------------------
  // clear character and running watchdog
  // ---------------------------------------------------------------
  logic clrPrev_ff;
  logic clrPulse_ff;
  logic nxt_clrPulse;
  logic alivePrev_ff;
  logic armed_ff;
  logic nxt_armed;
  logic [22:0] wd_ff;
  logic [22:0] nxt_wd;
  logic shut_ff;
  logic nxt_shut;
  logic aliveRise;

  // edges of held levels, since the controller pulses by two writes
  always_comb begin
    aliveRise = indicatorControl[`ROCM_BIT_ALIVE] & ~alivePrev_ff;
    nxt_clrPulse = motionWord[`ROCM_BIT_CLEAR_CHAR] & ~clrPrev_ff;
    nxt_armed = armed_ff | aliveRise;
    nxt_wd = wd_ff;
    nxt_shut = shut_ff;
    if (aliveRise) begin
      nxt_wd = 23'h00_0000;
    end else if (armed_ff && !shut_ff) begin
      if (wd_ff == ALIVE_LAST) begin
        nxt_shut = 1'b1;
      end else begin
        nxt_wd = wd_ff + 23'h00_0001;
      end
    end
  end

  // shutdown latches until reset; power drop is not recoverable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clrPrev_ff <= 1'b0;
      clrPulse_ff <= 1'b0;
      alivePrev_ff <= 1'b0;
      armed_ff <= 1'b0;
      wd_ff <= 23'h00_0000;
      shut_ff <= 1'b0;
    end else begin
      clrPrev_ff <= motionWord[`ROCM_BIT_CLEAR_CHAR];
      clrPulse_ff <= nxt_clrPulse;
      alivePrev_ff <= indicatorControl[`ROCM_BIT_ALIVE];
      armed_ff <= nxt_armed;
      wd_ff <= nxt_wd;
      shut_ff <= nxt_shut;
    end
  end

  assign clearCharPulse = clrPulse_ff;
  assign powerShutdown = shut_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence fontWrite;
    chanWr.write && chanWr.sel == `ROCM_CH_FONT;
  endsequence

  numeric_zero_a: assert property (fontWrite ##2 1'b1 |-> matrix_ff.numericZero ==
    ($past(chanWr.data[`ROCM_BIT_NUMERIC], 2) &&
     $past(chanWr.data[`ROCM_BIT_MARK_SENSE], 2)))
    else $error("zero matrix enable wrong");

  numeric_only_a: assert property (fontWrite ##2 1'b1 |->
    matrix_ff.numeric19 == $past(chanWr.data[`ROCM_BIT_NUMERIC], 2))
    else $error("numeric enable wrong");

  alpha_sets_a: assert property (fontWrite ##2 1'b1 |->
    matrix_ff.alpha5 == $past(chanWr.data[`ROCM_BIT_ALPHA5], 2) &&
    matrix_ff.alpha21 == $past(chanWr.data[`ROCM_BIT_ALPHA21], 2))
    else $error("alpha enable wrong");

  alt_font_a: assert property (fontWrite ##2 1'b1 |-> matrix_ff.altFont ==
    $past(chanWr.data[`ROCM_ALT_FONT_HI:`ROCM_ALT_FONT_LO], 2))
    else $error("alternate font enable wrong");

  pitch_decode_a: assert property (fontWrite ##0
    chanWr.data[`ROCM_PITCH_HI:`ROCM_PITCH_LO] == `ROCM_PITCH_CODE_8
    ##2 1'b1 |-> cpi_ff == `ROCM_CPI_8 && !open_ff)
    else $error("pitch 8 cpi not decoded");

  word_hold_a: assert property (!chanWr.write |=> $stable(word_ff[`ROCM_CH_MOTION]))
    else $error("word changed without a write");

  clear_pulse_a: assert property (clrPulse_ff |=> !clrPulse_ff)
    else $error("clear pulse longer than a cycle");

  shutdown_a: assert property (armed_ff && !shut_ff && !aliveRise && wd_ff == ALIVE_LAST
    |=> shut_ff ##1 shut_ff)
    else $error("shutdown not raised on missing running pulse");

  // flag set exactly when two or more speed lines are high
  conflict_a: assert property (conflict_ff ==
    (speed_ff != 4'h0 && (speed_ff & (speed_ff - 4'h1)) != 4'h0))
    else $error("speed conflict flag wrong");

  font_hold_a: assert property (chanWr.write && chanWr.sel != `ROCM_CH_FONT
    |=> $stable(word_ff[`ROCM_CH_FONT]))
    else $error("font word changed by another channel");

  clear_rise_a: assert property ($rose(motionWord[`ROCM_BIT_CLEAR_CHAR])
    |=> clrPulse_ff)
    else $error("clear pulse missing after rising clear line");

  alive_restart_a: assert property (aliveRise |=> wd_ff == 23'h00_0000 && armed_ff)
    else $error("running pulse did not restart watchdog");

  pitch_open_a: assert property (fontWrite ##0
    chanWr.data[`ROCM_PITCH_HI:`ROCM_PITCH_LO] == 2'h3
    ##2 1'b1 |-> cpi_ff == `ROCM_CPI_OPEN && open_ff)
    else $error("open pitch code not decoded");

endmodule : rocm_reader_map

// ---- tb/rocm_ctrl_model.sv ----
`timescale 1ns/1ns

// ---------------------------------------------------------------
// controller side: issues channel writes toward the reader map
// ---------------------------------------------------------------
module rocm_ctrl_model (
  input wire logic mclk,
  input wire logic rst_n,
  output rocm_pkg::rocm_chan_wr_t chanWr
);
  // bus idles with a non-matching pattern so a stale word never looks valid
  initial begin
    chanWr = '{write: 1'b0, sel: 3'h7, data: 16'hFFFF};
  end

  // one word per strobe, held whole for the sampling edge
  task automatic write_chan(input logic [2:0] sel, input logic [15:0] data, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    chanWr <= '{write: 1'b1, sel: sel, data: data};
    @(posedge mclk);
    // released bus shows the inverse, not the last word
    chanWr <= '{write: 1'b0, sel: ~sel, data: ~data};
  endtask : write_chan
endmodule : rocm_ctrl_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`include "rocm_cfg.svh"

module tb_top;
  localparam int unsigned ALIVE_CYC = 50;
  localparam int STEP_CYC = `ROCM_ACCEL_STEP_CYC;
  logic mclk;
  logic rst_n;
  rocm_pkg::rocm_chan_wr_t chanWr;
  logic [15:0] controllerStatus, transportStatus, readerOption, indicatorControl, mirSpeed;
  rocm_pkg::rocm_mir_state_t mirState;
  rocm_pkg::rocm_matrix_en_t matrixEn;
  rocm_pkg::rocm_video_t videoSet;
  logic [3:0] charsPerInch, advanceSpeed;
  logic pitchOpen, speedConflict, clearCharPulse, powerShutdown;
  logic [13:0] imageColumn;
  logic [1:0] imageCtl;
  int nFail, testsRun, pulseBase;
  int pulseCnt = 0;
  logic [15:0] wordPat [4] = '{16'hA5F0, 16'h8001, 16'h3C5A, 16'h5A3C};
  logic [15:0] fontIn [7] = '{16'h4000, 16'hC000, 16'h1000, 16'h0800, 16'h0080, 16'h0040,
                              16'h0020};
  logic [6:0] fontExp [7] = '{7'h08, 7'h0C, 7'h02, 7'h01, 7'h40, 7'h20, 7'h10};
  logic [3:0] cpiExp [4] = '{4'hA, 4'h8, 4'h7, 4'h0};

  // ---------------------------------------------------------------
  // clock, instances
  // ---------------------------------------------------------------
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  rocm_ctrl_model i_ctrl (.mclk(mclk), .rst_n(rst_n), .chanWr(chanWr));

  rocm_reader_map #(.ALIVE_TIMEOUT_CYC(ALIVE_CYC)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .chanWr(chanWr),
    .controllerStatus(controllerStatus), .transportStatus(transportStatus),
    .readerOption(readerOption), .indicatorControl(indicatorControl),
    .mirState(mirState), .mirSpeed(mirSpeed), .matrixEn(matrixEn),
    .charsPerInch(charsPerInch), .pitchOpen(pitchOpen), .advanceSpeed(advanceSpeed),
    .speedConflict(speedConflict), .videoSet(videoSet), .imageColumn(imageColumn),
    .imageCtl(imageCtl), .clearCharPulse(clearCharPulse), .powerShutdown(powerShutdown)
  );

  // counts cycles with the clear pulse high, so width and count are both seen
  always @(posedge mclk) begin
    if (clearCharPulse === 1'b1) pulseCnt++;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // let n edges pass, then step off the edge before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  // write then let the decoded outputs settle
  task automatic wr(input logic [2:0] sel, input logic [15:0] data);
    i_ctrl.write_chan(sel, data, 0);
    cyc(2);
  endtask : wr

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // bounded wait for a mirror phase; running out ends the run
  task automatic wait_mir(input rocm_pkg::rocm_mir_state_t st, input int lim);
    int n;
    n = 0;
    while (mirState !== st && n < lim) begin
      @(posedge mclk);
      n++;
    end
    #1;
    if (mirState !== st) begin
      nFail++;
      $display("mismatch at %0t: mirror phase never reached", $time);
      end_sim();
    end
  endtask : wait_mir

  // hang guard well above the longest expected run
  initial begin
    repeat (90000) @(posedge mclk);
    nFail++;
    $display("mismatch at %0t: run did not finish", $time);
    end_sim();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    nFail = 0;
    testsRun = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk(controllerStatus | transportStatus | readerOption | indicatorControl, 16'h0000, "words");
    chk({matrixEn, pitchOpen, advanceSpeed, speedConflict}, 16'h0000, "decoded reset");
    chk(charsPerInch, 4'hA, "pitch reset");
    chk(videoSet, 16'h0000, "video reset");
    chk({imageColumn, imageCtl}, 16'h0000, "image reset");
    chk({clearCharPulse, powerShutdown, mirState}, 16'h0000, "mirror reset");
    $display("test reset done");

    for (int i = 0; i < 4; i++) wr(i[2:0], wordPat[i]);
    wr(`ROCM_CH_FONT, 16'h0000);
    wr(`ROCM_CH_VIDEO, 16'h0000);
    chk(controllerStatus, wordPat[0], "word0");
    chk(transportStatus, wordPat[1], "word1");
    chk(readerOption, wordPat[2], "word2");
    chk(indicatorControl, wordPat[3], "word3");
    $display("test status words done");

    // numeric plus mark sense is the controller's way to full digits
    for (int i = 0; i < 7; i++) begin
      wr(`ROCM_CH_FONT, fontIn[i]);
      chk(matrixEn, fontExp[i], "matrix enables");
    end
    for (int p = 0; p < 4; p++) begin
      wr(`ROCM_CH_FONT, {11'h000, p[1:0], 3'h0});
      chk(charsPerInch, cpiExp[p], "pitch");
      chk(pitchOpen, (p == 3), "pitch open");
    end
    $display("test font and pitch done");

    for (int i = 0; i < 4; i++) begin
      wr(`ROCM_CH_MOTION, 16'h0001 << i);
      chk(advanceSpeed, 4'h1 << i, "advance speed");
      chk(speedConflict, 1'b0, "no conflict");
    end
    wr(`ROCM_CH_MOTION, 16'h0003);
    chk(speedConflict, 1'b1, "conflict flag");
    $display("test advance speed done");

    wr(`ROCM_CH_VIDEO, 16'hA5C3);
    chk(videoSet, 16'hA5C3, "video");
    wr(`ROCM_CH_VIDEO, 16'h5A3C);
    chk(videoSet, 16'h5A3C, "video");
    wr(`ROCM_CH_IMAGE, 16'hB6D9);
    chk(imageColumn, 14'h2DB6, "image column");
    chk(imageCtl, 2'h1, "image ctl");
    $display("test video and image done");

    pulseBase = pulseCnt;
    wr(`ROCM_CH_MOTION, 16'h0080);
    wr(`ROCM_CH_MOTION, 16'h0000);
    cyc(4);
    chk(16'(pulseCnt - pulseBase), 16'h0001, "clear pulse count");
    $display("test clear char done");

    // halt wins over accel, so nothing moves
    wr(`ROCM_CH_MOTION, 16'h2800);
    cyc(STEP_CYC + 10);
    chk(mirState, rocm_pkg::ROCM_MIR_IDLE, "halt state");
    chk(mirSpeed, 16'h0000, "halt speed");
    wr(`ROCM_CH_MOTION, 16'h2000);
    chk(mirState, rocm_pkg::ROCM_MIR_ACCEL, "accel");
    cyc(2 * STEP_CYC + 400);
    chk(mirSpeed, 16'h0002, "accel rate");
    // run past nominal so release really slows down; mid-step at 76 ips
    cyc(59600);
    chk(mirSpeed, 16'h004C, "accel above nominal");
    wr(`ROCM_CH_MOTION, 16'h0000);
    chk(mirState, rocm_pkg::ROCM_MIR_DECEL, "decel");
    chk(mirSpeed, 16'h004C, "decel start");
    wait_mir(rocm_pkg::ROCM_MIR_CRUISE, 2 * STEP_CYC);
    chk(mirSpeed, `ROCM_NOMINAL_IPS, "nominal speed");
    cyc(1000);
    chk(mirState, rocm_pkg::ROCM_MIR_CRUISE, "cruise state");
    chk(mirSpeed, 16'h004B, "cruise speed");
    wr(`ROCM_CH_MOTION, 16'h0800);
    chk(mirState, rocm_pkg::ROCM_MIR_IDLE, "stopped state");
    chk(mirSpeed, 16'h0000, "stopped speed");
    $display("test mirror done");

    cyc(2 * ALIVE_CYC);
    chk(powerShutdown, 1'b0, "not armed");
    for (int i = 0; i < 4; i++) begin
      wr(`ROCM_CH_INDICATOR, 16'h8000);
      wr(`ROCM_CH_INDICATOR, 16'h0000);
      cyc(20);
    end
    chk(powerShutdown, 1'b0, "kept alive");
    cyc(ALIVE_CYC + 10);
    chk(powerShutdown, 1'b1, "shutdown");
    $display("test watchdog done");

    // second reset mid-run clears the sticky shutdown and the words
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(1);
    chk(powerShutdown, 1'b0, "second reset shutdown");
    chk(indicatorControl, 16'h0000, "second reset words");
    $display("test second reset done");
    end_sim();
  end
endmodule : tb_top
